// ==== core/amp_fault_mode_manager.sv ====
/*
 Fault classification, reporting and mode control for a four-channel
 class-D amplifier. Assumes fault detector inputs and host select inputs are
 synchronous levels; host command inputs are single-cycle pulses.
*/
`timescale 1ns/1ps
// Summary of operation
// R1 - In play, pump, oscillator, control and supplies are on; outputs switch.
// R2 - Overheat warning: status and clip pin only, no action, self-clearing.
// R3 - Current limit caps channel, starts overcurrent timer, self-clears.
// R4 - Overcurrent mutes channel to floating, reports on fault pin, latches.
// R5 - Load diagnostics only when floating and host-triggered; status latched.
// R6 - Gain steps with mute ramp and status follows it.
// R7 - Common-mode ramp about 26 ms then gain ramp about 76 ms.
// R8 - Host programs identical settings into paralleled channels.
// R9 - Host commands paralleled channels together.
// R10 - Load diagnostics are supported on paralleled channels.
// R11 - Host watches foldback and lowers gain of paralleled pairs.
// R12 - Reset/dump: standby; low/high supply: floating, latched.
// R13 - DC offset mutes channel latched; clip drives pin; foldback lowers gain.
// R14 - Fault pin low whenever floating or standby is forced.
// R15 - Clip pin shows warning, clip or both; also tweeter presence.
// R16 - Standby in 1 ms if floating, else 20 ms ramp; state then lost (standby_req here keeps oc_q, dc_q and sup_q).
module amp_fault_mode_manager
    import amp_fault_pkg::*;
#(
    parameter int NCH = NUM_CH,
    parameter int CM_CYCLES = CM_RAMP_CYC,
    parameter int GAIN_CYCLES = GAIN_RAMP_CYC,
    parameter int DOWN_CYCLES = QUICK_DOWN_CYC,
    parameter int FAST_CYCLES = STBY_FAST_CYC,
    parameter int OC_CYCLES = 1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic por_event,
    input wire logic load_dump,
    input wire logic supply_low,
    input wire logic pump_supply_low,
    input wire logic supply_high,
    input wire logic overheat_warning,
    input wire logic overheat_shutdown,
    input wire logic [NCH-1:0] cycle_current_limit,
    input wire logic [NCH-1:0] dc_offset,
    input wire logic [NCH-1:0] clipping,
    input wire logic [NCH-1:0] thermal_foldback,
    input wire logic [NCH-1:0] load_open,
    input wire logic [NCH-1:0] load_short,
    input wire logic [NCH-1:0] tweeter_present,
    input wire logic diag_start,
    input wire logic tweeter_diag,
    input wire logic play_cmd,
    input wire logic float_cmd,
    input wire logic standby_req,
    input wire logic fault_clear,
    input wire logic [1:0] clip_warn_sel,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic clip_thermal_warn_n_o,
    output logic clip_thermal_warn_n_oe,
    output logic supplies_on,
    output logic [NCH-1:0] switching,
    output logic [NCH-1:0] current_limit,
    output logic [NCH-1:0] ch_floating,
    output logic [GAIN_W-1:0] ch_gain [NCH],
    output logic [NCH-1:0] oc_status,
    output logic [NCH-1:0] dc_status,
    output logic [NCH-1:0] open_status,
    output logic [NCH-1:0] short_status,
    output logic [NCH-1:0] foldback_status,
    output logic warn_status,
    output logic [2:0] supply_status,
    output logic overheat_status,
    output mode_type mode
);
    initial
    begin
        if (NCH < 1 || CM_CYCLES < 1 || GAIN_CYCLES < 1 || DOWN_CYCLES < 1
            || FAST_CYCLES < 1 || OC_CYCLES < 1)
            $error("amp_fault_mode_manager: bad parameter");
    end

    //------------------------------------------------------------
    // Fault latches
    //------------------------------------------------------------
    logic [NCH-1:0] oc_q;
    logic [NCH-1:0] dc_q;
    logic [NCH-1:0] open_q;
    logic [NCH-1:0] short_q;
    logic [2:0] sup_q;
    logic ots_q;
    logic [31:0] oc_cnt_q [NCH];
    logic [NCH-1:0] oc_trip;
    mode_type mode_q;
    logic standby_force;
    logic float_force;
    logic [NCH-1:0] ch_kill;

    function automatic logic [31:0] sat_dec(input logic [31:0] v);
        sat_dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction : sat_dec

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            oc_trip[i] = cycle_current_limit[i] && (oc_cnt_q[i] == 32'h1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < NCH; i++)
                oc_cnt_q[i] <= 32'h0;
        else
            for (int i = 0; i < NCH; i++)
                if (!cycle_current_limit[i])
                    oc_cnt_q[i] <= 32'h0;
                else if (oc_cnt_q[i] == 32'h0)
                    oc_cnt_q[i] <= 32'(OC_CYCLES) + 32'h1; // R3
                else
                    oc_cnt_q[i] <= sat_dec(oc_cnt_q[i]);
    end

    wire live = (mode_q != ST_STANDBY);
    wire [2:0] sup_in = {supply_high, pump_supply_low, supply_low};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            oc_q <= '0;
            dc_q <= '0;
            sup_q <= 3'h0;
            ots_q <= 1'b0;
        end
        else if (standby_force)
        begin
            oc_q <= '0; // R16
            dc_q <= '0;
            sup_q <= 3'h0;
            // Host clear releases the shutdown latch; set wins
            ots_q <= (fault_clear ? 1'b0 : ots_q)
                | (overheat_shutdown & live); // R12
        end
        else
        begin
            // Set wins over clear
            oc_q <= (fault_clear ? '0 : oc_q) | oc_trip; // R4
            dc_q <= (fault_clear ? '0 : dc_q)
                | (dc_offset & {NCH{mode_q == ST_PLAY}}); // R13
            sup_q <= (fault_clear ? 3'h0 : sup_q)
                | (sup_in & {3{live}}); // R12
            ots_q <= (fault_clear ? 1'b0 : ots_q)
                | (overheat_shutdown & live); // R12
        end
    end

    wire diag_ok = (mode_q == ST_FLOAT) && diag_start;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            open_q <= '0;
            short_q <= '0;
        end
        else if (mode_q == ST_STANDBY)
        begin
            open_q <= '0;
            short_q <= '0;
        end
        else if (diag_ok)
        begin
            open_q <= load_open; // R5 R10
            short_q <= load_short; // R5
        end
    end

    //------------------------------------------------------------
    // Mode sequencing
    //------------------------------------------------------------
    logic tmr_load;
    logic [31:0] tmr_value;
    logic [31:0] tmr_left;
    logic tmr_done;
    logic leaving_q;

    ramp_timer #(.WIDTH(32)) u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .load_value(tmr_value),
        .remaining(tmr_left),
        .done(tmr_done)
    );

    assign standby_force = por_event | load_dump | ots_q; // R12
    assign float_force = |sup_q; // R12
    assign ch_kill = oc_q | dc_q; // R4 R13

    always_comb
    begin
        tmr_load = 1'b0;
        tmr_value = 32'h0;
        if (!standby_force && standby_req && !leaving_q)
        begin
            tmr_load = 1'b1; // R16
            tmr_value = (mode_q == ST_FLOAT || mode_q == ST_STANDBY)
                ? 32'(FAST_CYCLES) : 32'(DOWN_CYCLES);
        end
        else if (mode_q == ST_FLOAT && play_cmd && !float_force
                 && !leaving_q)
        begin
            tmr_load = 1'b1;
            tmr_value = 32'(CM_CYCLES); // R7
        end
        else if (mode_q == ST_CM_RAMP && tmr_done && !leaving_q)
        begin
            tmr_load = 1'b1;
            tmr_value = 32'(GAIN_CYCLES); // R7
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= ST_FLOAT;
            leaving_q <= 1'b0;
        end
        else if (standby_force)
        begin
            mode_q <= ST_STANDBY; // R12
            leaving_q <= 1'b0;
        end
        else if (leaving_q)
        begin
            if (tmr_done)
            begin
                mode_q <= ST_STANDBY; // R16
                leaving_q <= 1'b0;
            end
        end
        else if (standby_req)
            leaving_q <= 1'b1;
        else if (float_force || float_cmd)
            mode_q <= ST_FLOAT; // R12
        else
            case (mode_q)
                ST_STANDBY:
                    if (play_cmd || float_cmd)
                        mode_q <= ST_FLOAT;
                ST_FLOAT:
                    if (play_cmd)
                        mode_q <= ST_CM_RAMP;
                ST_CM_RAMP:
                    if (tmr_done)
                        mode_q <= ST_GAIN_UP;
                ST_GAIN_UP:
                    if (tmr_done)
                        mode_q <= ST_PLAY;
                ST_PLAY:
                    mode_q <= ST_PLAY;
                default:
                    mode_q <= ST_FLOAT;
            endcase
    end

    //------------------------------------------------------------
    // Gain and outputs
    //------------------------------------------------------------
    function automatic logic [GAIN_W-1:0] ramp_gain(input logic [31:0] left);
        logic [63:0] p;
        p = 64'(GAIN_CYCLES - 32'(left)) * 64'(GAIN_FULL);
        ramp_gain = GAIN_W'(p / 64'(GAIN_CYCLES));
    endfunction : ramp_gain

    logic [GAIN_W-1:0] base_gain;

    always_comb
    begin
        base_gain = GAIN_ZERO;
        if (leaving_q && mode_q != ST_FLOAT && mode_q != ST_STANDBY)
            base_gain = GAIN_W'((64'(tmr_left) * 64'(GAIN_FULL))
                / 64'(DOWN_CYCLES)); // R6
        else if (mode_q == ST_GAIN_UP)
            base_gain = ramp_gain(tmr_left); // R6
        else if (mode_q == ST_PLAY)
            base_gain = GAIN_FULL;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < NCH; i++)
                ch_gain[i] <= GAIN_ZERO;
        else
            for (int i = 0; i < NCH; i++)
                if (ch_kill[i])
                    ch_gain[i] <= GAIN_ZERO; // R4
                else if (thermal_foldback[i])
                    ch_gain[i] <= base_gain >> FOLDBACK_SHIFT; // R13
                else
                    ch_gain[i] <= base_gain;
    end

    wire active = (mode_q != ST_STANDBY) && (mode_q != ST_FLOAT);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            switching <= '0;
            ch_floating <= {NCH{1'b1}};
            supplies_on <= 1'b0;
            current_limit <= '0;
        end
        else
        begin
            switching <= {NCH{active}} & ~ch_kill; // R1
            ch_floating <= ~({NCH{active}} & ~ch_kill); // R4
            supplies_on <= (mode_q != ST_STANDBY); // R1
            current_limit <= cycle_current_limit & {NCH{active}}; // R3
        end
    end

    logic warn_pin;

    always_comb
    begin
        case (clip_warn_sel)
            CW_SEL_WARN: warn_pin = overheat_warning; // R2
            CW_SEL_CLIP: warn_pin = |clipping; // R13
            CW_SEL_BOTH: warn_pin = overheat_warning | (|clipping); // R15
            default: warn_pin = overheat_warning;
        endcase
        if (tweeter_diag && mode_q == ST_FLOAT && |tweeter_present)
            warn_pin = 1'b1; // R15
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clip_thermal_warn_n_oe <= 1'b0;
            fault_n_oe <= 1'b0;
        end
        else
        begin
            clip_thermal_warn_n_oe <= warn_pin && live;
            fault_n_oe <= standby_force | float_force | (|ch_kill); // R14
        end
    end

    assign fault_n_o = 1'b0;
    assign clip_thermal_warn_n_o = 1'b0;
    assign mode = mode_q;
    assign oc_status = oc_q;
    assign dc_status = dc_q;
    assign open_status = open_q;
    assign short_status = short_q;
    assign foldback_status = thermal_foldback & {NCH{live}};
    assign warn_status = overheat_warning & live; // R2
    assign supply_status = sup_q;
    assign overheat_status = ots_q;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    oc_floats_a: assert property (@(posedge clk) disable iff (rst) // R4
        oc_trip != '0 |=> ##1
        (ch_floating & ~switching & $past(oc_trip, 2)) == $past(oc_trip, 2))
        else $error("overcurrent did not float channel");
    fault_pin_a: assert property (@(posedge clk) disable iff (rst) // R14
        (float_force || standby_force) |=> fault_n_oe)
        else $error("fault pin not driven");
    dump_standby_a: assert property (@(posedge clk) disable iff (rst) // R12
        load_dump |=> mode_q == ST_STANDBY)
        else $error("load dump did not enter standby");
    diag_gate_a: assert property (@(posedge clk) disable iff (rst) // R5
        mode_q != ST_FLOAT && !standby_force |=> $stable(open_q)
        || mode_q == ST_STANDBY)
        else $error("diagnostic outside floating state");
    warn_only_a: assert property (@(posedge clk) disable iff (rst) // R2
        overheat_warning && clip_warn_sel == CW_SEL_WARN && live
        && !standby_force |=> clip_thermal_warn_n_oe)
        else $error("warning not on clip pin");
    play_full_a: assert property (@(posedge clk) disable iff (rst) // R6
        mode_q == ST_PLAY && !leaving_q && ch_kill == '0
        && thermal_foldback == '0 |=> ch_gain[0] == GAIN_FULL)
        else $error("gain not full in play");
    cm_ramp_a: assert property (@(posedge clk) disable iff (rst) // R7
        $rose(mode_q == ST_CM_RAMP) |-> tmr_left == 32'(CM_CYCLES))
        else $error("common-mode ramp length wrong");
    float_stby_a: assert property (@(posedge clk) disable iff (rst) // R16
        mode_q == ST_FLOAT && standby_req && !leaving_q && !standby_force
        |=> tmr_left == 32'(FAST_CYCLES))
        else $error("fast standby length wrong");
    play_on_a: assert property (@(posedge clk) disable iff (rst) // R1
        mode_q == ST_PLAY && ch_kill == '0 |=> switching != '0
        || standby_force)
        else $error("not switching in play");
endmodule : amp_fault_mode_manager

// ==== shared/amp_fault_pkg.sv ====
/*
 Constants and types for the amplifier fault and operating-mode manager.
 Assumes a 200 MHz system clock.
*/
package amp_fault_pkg;
    localparam int CLK_MHZ = 200;
    localparam int NUM_CH = 4;
    // Ramp and standby times in microseconds at the default mute capacitor
    localparam int CM_RAMP_US = 26000;
    localparam int GAIN_RAMP_US = 76000;
    localparam int QUICK_DOWN_US = 20000;
    localparam int STBY_FAST_US = 1000;
    localparam int CM_RAMP_CYC = CM_RAMP_US * CLK_MHZ;
    localparam int GAIN_RAMP_CYC = GAIN_RAMP_US * CLK_MHZ;
    localparam int QUICK_DOWN_CYC = QUICK_DOWN_US * CLK_MHZ;
    localparam int STBY_FAST_CYC = STBY_FAST_US * CLK_MHZ;
    localparam int GAIN_W = 8;
    localparam logic [7:0] GAIN_FULL = 8'hff;
    localparam logic [7:0] GAIN_ZERO = 8'h00;
    localparam logic [7:0] FOLDBACK_SHIFT = 8'h01;
    // Clip/warning pin source selection
    localparam logic [1:0] CW_SEL_WARN = 2'h0;
    localparam logic [1:0] CW_SEL_CLIP = 2'h1;
    localparam logic [1:0] CW_SEL_BOTH = 2'h2;

    typedef enum logic [4:0] {
        ST_STANDBY = 5'h01,
        ST_FLOAT = 5'h02,
        ST_CM_RAMP = 5'h04,
        ST_GAIN_UP = 5'h08,
        ST_PLAY = 5'h10
    } mode_type;
endpackage : amp_fault_pkg

// ==== core/ramp_timer.sv ====
/*
 Down counter used for mute-pin ramp timing.
 Assumes load and count are synchronous to clk.
*/
`timescale 1ns/1ps
module ramp_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] remaining,
    output logic done
);
    logic [WIDTH-1:0] count_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_q <= '0;
        else if (load)
            count_q <= load_value;
        else if (count_q != '0)
            count_q <= count_q - 1'b1;
    end

    assign remaining = count_q;
    // Done depends only on the count, so a caller may load on done
    assign done = (count_q == '0);
endmodule : ramp_timer

// ==== testbench/host_model.sv ====
/*
 Host controller model: issues one-cycle command pulses and holds the
 clip/warning source selection and tweeter-test level.
 Assumes callers act just after a rising edge of clk.
*/
`timescale 1ns/1ps
module host_model
    import amp_fault_pkg::*;
(
    input wire logic clk,
    output logic diag_start,
    output logic tweeter_diag,
    output logic play_cmd,
    output logic float_cmd,
    output logic standby_req,
    output logic fault_clear,
    output logic [1:0] clip_warn_sel
);
    logic [4:0] cmd_q;

    // One command word reaches every channel in the same cycle
    assign {fault_clear, standby_req, float_cmd, play_cmd, diag_start} =
        cmd_q;

    initial
    begin
        cmd_q = 5'h00;
        clip_warn_sel = CW_SEL_WARN;
        tweeter_diag = 1'b0;
    end

    task automatic send(input logic [4:0] cmd);
        cmd_q = cmd;
        @(posedge clk);
        #1;
        cmd_q = 5'h00;
        @(posedge clk);
        #1;
    endtask : send

    task automatic configure(input logic [1:0] sel, input logic tweet);
        clip_warn_sel = sel;
        tweeter_diag = tweet;
    endtask : configure
endmodule : host_model

// ==== testbench/test_amp_fault_mode_manager.sv ====
/*
 Self-checking bench for the fault and mode manager.
 Assumes shortened ramp counts and the host model as command source.
*/
`timescale 1ns/1ps
module test_amp_fault_mode_manager;
    import amp_fault_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int CM_C = 20;
    localparam int GAIN_C = 20;
    localparam int DOWN_C = 20;
    localparam int FAST_C = 10;
    localparam int OC_C = 8;
    localparam int LIMIT = 5000;
    localparam logic [4:0] CMD_DIAG = 5'h01;
    localparam logic [4:0] CMD_PLAY = 5'h02;
    localparam logic [4:0] CMD_FLOAT = 5'h04;
    localparam logic [4:0] CMD_STBY = 5'h08;
    localparam logic [4:0] CMD_CLR = 5'h10;
    logic clk, rst, por_event, load_dump, overheat_warning, overheat_shutdown;
    logic supply_low, pump_supply_low, supply_high;
    logic [2:0] supply_v;
    logic [NUM_CH-1:0] cycle_current_limit, dc_offset, clipping;
    logic [NUM_CH-1:0] thermal_foldback, load_open, load_short;
    logic [NUM_CH-1:0] tweeter_present;
    logic diag_start, tweeter_diag, play_cmd, float_cmd, standby_req;
    logic fault_clear, fault_n_o, fault_n_oe, supplies_on, warn_status;
    logic clip_thermal_warn_n_o, clip_thermal_warn_n_oe, overheat_status;
    logic [1:0] clip_warn_sel;
    logic [NUM_CH-1:0] switching, current_limit, ch_floating, oc_status;
    logic [NUM_CH-1:0] dc_status, open_status, short_status, foldback_status;
    logic [GAIN_W-1:0] ch_gain [NUM_CH];
    logic [2:0] supply_status;
    mode_type mode;
    logic fault_pin, clip_pin;
    int error_cnt, checks_done, cycles, n, i;

    // Open-drain pins with pull-ups
    assign fault_pin = fault_n_oe ? fault_n_o : 1'b1;
    assign clip_pin = clip_thermal_warn_n_oe ? clip_thermal_warn_n_o : 1'b1;
    assign {supply_high, pump_supply_low, supply_low} = supply_v;

    amp_fault_mode_manager #(.NCH(NUM_CH), .CM_CYCLES(CM_C),
        .GAIN_CYCLES(GAIN_C), .DOWN_CYCLES(DOWN_C), .FAST_CYCLES(FAST_C),
        .OC_CYCLES(OC_C)) amp_fault_mode_manager_inst (
        .clk, .rst, .por_event, .load_dump, .supply_low, .pump_supply_low,
        .supply_high, .overheat_warning, .overheat_shutdown,
        .cycle_current_limit, .dc_offset, .clipping, .thermal_foldback,
        .load_open, .load_short, .tweeter_present, .diag_start,
        .tweeter_diag, .play_cmd, .float_cmd, .standby_req, .fault_clear,
        .clip_warn_sel, .fault_n_o, .fault_n_oe, .clip_thermal_warn_n_o,
        .clip_thermal_warn_n_oe, .supplies_on, .switching, .current_limit,
        .ch_floating, .ch_gain, .oc_status, .dc_status, .open_status,
        .short_status, .foldback_status, .warn_status, .supply_status,
        .overheat_status, .mode);

    host_model host_model_inst (.clk, .diag_start, .tweeter_diag,
        .play_cmd, .float_cmd, .standby_req, .fault_clear, .clip_warn_sel);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_mode(input mode_type got, input mode_type exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_mode

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wait_mode(input mode_type m, input int lim, output int cnt);
        cnt = 0;
        while (mode !== m && cnt < lim)
        begin
            cyc(1);
            cnt++;
        end
        check_mode(mode, m);
    endtask : wait_mode

    task automatic go_play;
        host_model_inst.send(CMD_PLAY);
        check_mode(mode, ST_CM_RAMP);
        wait_mode(ST_GAIN_UP, CM_C + 8, n);
        check_val(n >= CM_C - 3, 1);
        cyc(GAIN_C / 2);
        check_val(ch_gain[0] != GAIN_ZERO && ch_gain[0] != GAIN_FULL, 1);
        wait_mode(ST_PLAY, GAIN_C + 8, n);
        cyc(2);
        check_val(ch_gain[3], GAIN_FULL);
        check_val({3'h0, supplies_on, switching}, 8'h1f);
        check_val(ch_floating, 0);
    endtask : go_play

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            error_cnt++;
            summarize();
        end
    end

    initial
    begin
        {rst, por_event, load_dump, overheat_warning, overheat_shutdown} = 5'h10;
        {supply_v, cycle_current_limit, dc_offset, clipping} = 15'h0000;
        {thermal_foldback, load_open, load_short, tweeter_present} = 16'h0000;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check_mode(mode, ST_FLOAT);
        check_val({ch_floating, oc_status}, 8'hf0);
        go_play();
        for (i = 0; i < 3; i++)
        begin
            host_model_inst.configure(i[1:0], 1'b0);
            overheat_warning = 1'b1;
            cyc(3);
            check_val(clip_pin, i[1:0] == CW_SEL_CLIP);
            check_val(warn_status, 1);
            check_mode(mode, ST_PLAY);
            overheat_warning = 1'b0;
            clipping = 4'h8;
            cyc(3);
            check_val(clip_pin, i[1:0] == CW_SEL_WARN);
            clipping = 4'h0;
            cyc(3);
            check_val(clip_pin, 1);
        end
        host_model_inst.configure(CW_SEL_WARN, 1'b0);
        thermal_foldback = 4'h2;
        cyc(3);
        check_val(foldback_status, 4'h2);
        check_val(ch_gain[1], GAIN_FULL >> FOLDBACK_SHIFT);
        check_val(ch_gain[0], GAIN_FULL);
        thermal_foldback = 4'h0;
        cyc(3);
        check_val(ch_gain[1], GAIN_FULL);
        cycle_current_limit = 4'h4;
        cyc(2);
        check_val(current_limit, 4'h4);
        cyc(OC_C - 5);
        cycle_current_limit = 4'h0;
        cyc(3);
        check_val({current_limit, oc_status}, 0);
        cycle_current_limit = 4'h4;
        cyc(OC_C + 4);
        cycle_current_limit = 4'h0;
        cyc(3);
        check_val({oc_status, ch_floating}, 8'h44);
        check_val({fault_pin, 3'h0, switching}, 8'h0b);
        host_model_inst.send(CMD_CLR);
        check_val(oc_status, 0);
        dc_offset = 4'h1;
        cyc(3);
        dc_offset = 4'h0;
        cyc(2);
        check_val({dc_status[0], ch_floating[0]}, 8'h03);
        host_model_inst.send(CMD_CLR);
        check_val(dc_status, 0);
        load_open = 4'h5;
        load_short = 4'ha;
        host_model_inst.send(CMD_DIAG);
        check_val({open_status, short_status}, 0);
        overheat_shutdown = 1'b1;
        cyc(3);
        check_mode(mode, ST_STANDBY);
        check_val(fault_pin, 0);
        overheat_shutdown = 1'b0;
        cyc(5);
        check_mode(mode, ST_STANDBY);
        check_val(overheat_status, 1);
        host_model_inst.send(CMD_CLR);
        check_val(overheat_status, 0);
        host_model_inst.send(CMD_FLOAT);
        check_mode(mode, ST_FLOAT);
        host_model_inst.send(CMD_DIAG);
        {load_open, load_short} = 8'h00;
        cyc(2);
        check_val({open_status, short_status}, 8'h5a);
        check_mode(mode, ST_FLOAT);
        host_model_inst.configure(CW_SEL_CLIP, 1'b1);
        tweeter_present = 4'h2;
        cyc(3);
        check_val(clip_pin, 0);
        host_model_inst.configure(CW_SEL_WARN, 1'b0);
        tweeter_present = 4'h0;
        cyc(3);
        check_val(clip_pin, 1);
        for (i = 0; i < 3; i++)
        begin
            supply_v = 3'h1 << i;
            cyc(3);
            check_val(fault_pin, 0);
            supply_v = 3'h0;
            cyc(2);
            check_val(supply_status, 3'h1 << i);
            host_model_inst.send(CMD_PLAY);
            check_mode(mode, ST_FLOAT);
            host_model_inst.send(CMD_CLR);
            check_val({fault_pin, 1'b0, supply_status}, 8'h10);
        end
        host_model_inst.send(CMD_STBY);
        wait_mode(ST_STANDBY, FAST_C + 8, n);
        check_val(n >= FAST_C - 3, 1);
        cyc(2);
        check_val({open_status, short_status}, 0);
        host_model_inst.send(CMD_PLAY);
        check_mode(mode, ST_FLOAT);
        for (i = 0; i < 2; i++)
        begin
            por_event = (i == 0);
            load_dump = (i == 1);
            cyc(3);
            check_mode(mode, ST_STANDBY);
            check_val(fault_pin, 0);
            {por_event, load_dump} = 2'h0;
            cyc(3);
            host_model_inst.send(CMD_FLOAT);
            check_mode(mode, ST_FLOAT);
        end
        go_play();
        host_model_inst.send(CMD_STBY);
        cyc(DOWN_C / 2 - 2);
        check_val(ch_gain[2] < GAIN_FULL && mode != ST_STANDBY, 1);
        wait_mode(ST_STANDBY, DOWN_C + 8, n);
        summarize();
    end
endmodule : test_amp_fault_mode_manager
